// ==== verification/unvm_byte_read_port_properties.sv ====
// Checker of the byte read port and the bank programming handshake.
// Assumes it is bound to unvm_byte_read_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module unvm_read_port_checker (
  input wire logic       clk_sys,     // System clock.
  input wire logic       resetn,      // Reset, active low.
  input wire logic [6:0] rd_addr,     // Fabric read address.
  input wire logic [7:0] rd_data,     // Fabric read data.
  input wire logic       tp_tck,      // Shift clock pin.
  input wire logic       tp_tdi,      // Serial data pin.
  input wire logic       tp_prog_sel, // Program mode pin.
  input wire logic       tp_update,   // Commit pin.
  input wire logic [2:0] tp_bank,     // Target bank pins.
  input wire logic       prog_busy,   // Program running.
  input wire logic       prog_done,   // End of program pulse.
  input wire logic       prog_reject  // Last commit refused.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // --------------------------------------------------------------------
  // Programming sequence
  // --------------------------------------------------------------------
  // Erase and write together keep the store busy for exactly sixteen plus eight cycles.
  property p_busy_len;
    $rose(prog_busy) |-> prog_busy[*8] ##1 prog_busy[*8] ##1 prog_busy[*8] ##1 !prog_busy;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_done_time;
    $rose(prog_busy) |-> ##24 prog_done;
  endproperty
  a_done_time: assert property (p_done_time) else $error("no done in time");
  property p_done_fell;
    prog_done |-> $fell(prog_busy);
  endproperty
  a_done_fell: assert property (p_done_fell) else $error("done without busy end");
  property p_done_pulse;
    prog_done |=> !prog_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_done_ok;
    prog_done |-> !prog_reject;
  endproperty
  a_done_ok: assert property (p_done_ok) else $error("done while rejected");
  // A refused commit must never start an erase.
  property p_reject_idle;
    $rose(prog_reject) |-> !prog_busy[*3];
  endproperty
  a_reject_idle: assert property (p_reject_idle) else $error("busy after reject");
  property p_busy_clears;
    $rose(prog_busy) |=> !prog_reject[*8];
  endproperty
  a_busy_clears: assert property (p_busy_clears) else $error("reject kept");

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  // The store is undefined until a bank is first programmed, so reads count after that.
  logic seen_done_ff;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seen_done_ff <= 1'b0;
    end else if (prog_done) begin
      seen_done_ff <= 1'b1;
    end
  end

  // Data may only move when the captured address or the store has moved.
  property p_read_hold;
    @(negedge clk_sys) ($stable(rd_addr) && !prog_busy && !$past(prog_busy)
      && $past(resetn, 2) && seen_done_ff) |=> $stable(rd_data);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved");

  c_prog: cover property ($rose(prog_busy));
  c_done: cover property (prog_done);
  c_rej: cover property ($rose(prog_reject));
endmodule

bind unvm_byte_read_port unvm_read_port_checker unvm_read_port_checker_inst (
  .clk_sys(clk_sys), .resetn(resetn), .rd_addr(rd_addr), .rd_data(rd_data),
  .tp_tck(tp_tck), .tp_tdi(tp_tdi), .tp_prog_sel(tp_prog_sel), .tp_update(tp_update),
  .tp_bank(tp_bank), .prog_busy(prog_busy), .prog_done(prog_done),
  .prog_reject(prog_reject));

`default_nettype wire

// ==== verification/unvm_byte_read_port_tb.sv ====
// Bench of the byte read port: loads banks through the test pins, reads back.
// Assumes the design files and the fabric model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module unvm_byte_read_port_tb;
  logic         clk_sys, resetn, tp_tck, tp_tdi, tp_prog_sel, tp_update;
  logic [2:0]   tp_bank;
  logic [6:0]   req_addr, rd_addr;
  logic [7:0]   rd_data;
  logic         prog_busy, prog_done, prog_reject;
  logic [127:0] mem [8];
  int           error_cnt, n_checks, cyc;

  unvm_byte_read_port unvm_byte_read_port_inst (.clk_sys(clk_sys), .resetn(resetn),
    .rd_addr(rd_addr), .rd_data(rd_data), .tp_tck(tp_tck), .tp_tdi(tp_tdi),
    .tp_prog_sel(tp_prog_sel), .tp_update(tp_update), .tp_bank(tp_bank),
    .prog_busy(prog_busy), .prog_done(prog_done), .prog_reject(prog_reject));
  unvm_fabric_model unvm_fabric_model_inst (.clk_sys(clk_sys), .req_addr(req_addr),
    .rd_addr(rd_addr));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected byte at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected flag at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [127:0] pat(input int s);
    logic [127:0] r;
    for (int k = 0; k < 16; k++) r[k*8 +: 8] = 8'(s * 29 + k * 13 + 1);
    return r;
  endfunction

  // Each pin level is held four cycles so the two-flop sync sees it.
  task automatic shift_commit(input logic [2:0] b, input logic [127:0] d, input int n);
    @(negedge clk_sys);
    tp_prog_sel = 1'b1;
    tp_bank = b;
    for (int i = 0; i < n; i++) begin
      tp_tdi = d[i % 128];
      repeat (4) @(negedge clk_sys);
      tp_tck = 1'b1;
      repeat (4) @(negedge clk_sys);
      tp_tck = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    tp_update = 1'b1;
    repeat (4) @(negedge clk_sys);
    tp_update = 1'b0;
  endtask

  // Busy must already stand when the commit task returns, and fall with done.
  task automatic prog_bank(input logic [2:0] b, input logic [127:0] d);
    int i;
    shift_commit(b, d, 128);
    chk1(prog_busy, 1'b1);
    for (i = 0; i < 60 && prog_done !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk1(prog_done, 1'b1);
    chk1(prog_busy, 1'b0);
    chk1(prog_reject, 1'b0);
    mem[b] = d;
    @(negedge clk_sys);
    tp_prog_sel = 1'b0;
  endtask

  // Back-to-back reads of every address; each byte is judged just after the falling
  // edge of its capture cycle, so a byte that comes a full cycle late is caught.
  task automatic read_all;
    for (int i = 0; i < 129; i++) begin
      @(posedge clk_sys);
      #1;
      if (i < 128) req_addr = 7'(i);
      @(negedge clk_sys);
      #1;
      if (i >= 1) chk8(rd_data, mem[(i - 1) >> 4][((i - 1) % 16) * 8 +: 8]);
    end
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_load;
    for (int b = 0; b < 8; b++) prog_bank(3'(b), pat(b));
    read_all();
    $display("test load and read done");
  endtask

  task automatic t_rebank;
    prog_bank(3'd3, ~pat(3));
    read_all();
    $display("test single bank reprogram done");
  endtask

  // A short load and an overlong load are both refused and leave the store alone.
  task automatic t_reject;
    shift_commit(3'd5, pat(9), 100);
    chk1(prog_busy, 1'b0);
    repeat (40) @(negedge clk_sys);
    chk1(prog_reject, 1'b1);
    chk1(prog_busy, 1'b0);
    tp_prog_sel = 1'b0;
    shift_commit(3'd5, pat(9), 129);
    chk1(prog_busy, 1'b0);
    repeat (40) @(negedge clk_sys);
    chk1(prog_reject, 1'b1);
    tp_prog_sel = 1'b0;
    read_all();
    prog_bank(3'd6, pat(12));
    read_all();
    $display("test refused commit done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // The whole run takes about 13000 cycles.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    {resetn, tp_tck, tp_tdi, tp_prog_sel, tp_update} = 5'h00;
    tp_bank = 3'h0;
    req_addr = 7'h00;
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_load();
    t_rebank();
    t_reject();
    finish_test();
  end
endmodule

`default_nettype wire

// ==== verification/unvm_fabric_model.sv ====
// Fabric logic that presents read addresses to the byte read port.
// Assumes the bench hands it one address request per cycle.
`timescale 1ns/1ps
`default_nettype none

module unvm_fabric_model (
  input  wire logic       clk_sys,  // System clock.
  input  wire logic [6:0] req_addr, // Address the bench wants read.
  output logic      [6:0] rd_addr   // Address presented to the port.
);
  // Moving at the falling edge keeps the address still around each rising edge.
  always_ff @(negedge clk_sys) begin
    rd_addr <= req_addr;
  end
endmodule

`default_nettype wire

// ==== verilog/unvm_bank_store.sv ====
// Eight banks of 128 bits with whole-bank erase and write and a byte read mux.
// Assumes the caller raises at most one of erase or write per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "unvm_params.svh"

module unvm_bank_store
  import unvm_pkg::*;
(
  input  wire logic            clk_sys,   // System clock.
  input  wire logic            erase_stb, // Erase the selected bank to all ones.
  input  wire logic            write_stb, // Program the selected bank.
  input  wire unvm_bank_t      wr_bank,   // Bank being erased or programmed.
  input  wire unvm_bank_bits_t wr_bits,   // New bank contents.
  input  wire unvm_addr_t      rd_addr,   // Captured read address.
  output logic [7:0]           rd_byte    // Selected byte, combinational.
);

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic unvm_bank_t addr_bank(input unvm_addr_t a);
    addr_bank = a[`UNVM_ADDR_BANK_MSB:`UNVM_ADDR_BANK_LSB];
  endfunction

  function automatic unvm_byte_idx_t addr_byte(input unvm_addr_t a);
    addr_byte = a[`UNVM_ADDR_BYTE_MSB:`UNVM_ADDR_BYTE_LSB];
  endfunction

  // --------------------------------------------------------------------------
  // Bank storage
  // --------------------------------------------------------------------------
  unvm_bank_bits_t bank_ff [0:`UNVM_BANKS-1];

  genvar b;
  generate
    for (b = 0; b < `UNVM_BANKS; b++) begin : g_bank
      unvm_bank_bits_t nxt_bank;

      // Only the addressed bank moves; the others keep their bits.
      always_comb begin
        nxt_bank = bank_ff[b];
        if (erase_stb && (wr_bank == unvm_bank_t'(b))) begin
          nxt_bank = `UNVM_ERASED_BANK;
        end else if (write_stb && (wr_bank == unvm_bank_t'(b))) begin
          // Programming only clears bits, so a prior erase is required.
          nxt_bank = bank_ff[b] & wr_bits;
        end
      end

      // No reset: the contents model nonvolatile cells and survive it.
      always_ff @(posedge clk_sys) begin
        bank_ff[b] <= nxt_bank;
      end
    end
  endgenerate

  // Byte select within the addressed bank.
  always_comb begin
    rd_byte = bank_ff[addr_bank(rd_addr)][addr_byte(rd_addr)*8 +: 8];
  end

endmodule

`default_nettype wire

// ==== verilog/unvm_byte_read_port.sv ====
// User nonvolatile byte store: fabric read port and test-port bank programming.
// Assumes rd_addr comes from fabric logic on clk_sys and the test-port pins
// come from outside this clock domain.
//
// Summary of operation
// - Store holds 1,024 nonvolatile bits.
// - Fabric may read but never modify.
// - Eight banks, sixteen bytes each.
// - Programming only through the test port.
// - One bank reprogrammed, others untouched.
// - Reject partial or straddling bank loads.
// - Bank erased automatically before programming.
// - Read address captured on rising edge.
// - Read data valid after same-cycle falling edge.
// - Reads return one aligned whole byte.
// - Address bits 6 to 4 pick bank.
// - Address bits 3 to 0 pick byte.
`timescale 1ns/1ps
`default_nettype none
`include "unvm_params.svh"

module unvm_byte_read_port
  import unvm_pkg::*;
(
  input  wire logic             clk_sys,     // System clock, 25 MHz.
  input  wire logic             resetn,      // Asynchronous reset, active low.
  input  wire logic [6:0]       rd_addr,     // Fabric read address.
  output logic [7:0]            rd_data,     // Fabric read data.
  input  wire logic             tp_tck,      // Test-port shift clock pin.
  input  wire logic             tp_tdi,      // Test-port serial data pin.
  input  wire logic             tp_prog_sel, // Test-port bank program mode pin.
  input  wire logic             tp_update,   // Test-port commit pin.
  input  wire logic [2:0]       tp_bank,     // Test-port target bank pins.
  output logic                  prog_busy,   // Erase or program in progress.
  output logic                  prog_done,   // One-cycle pulse at end of program.
  output logic                  prog_reject  // Last commit rejected.
);

  // --------------------------------------------------------------------------
  // Test-port pin synchronisers
  // --------------------------------------------------------------------------
  logic [`UNVM_SYNC_W-1:0] sync1_ff;
  logic [`UNVM_SYNC_W-1:0] sync2_ff;
  logic [`UNVM_SYNC_W-1:0] nxt_sync1;
  logic [`UNVM_SYNC_W-1:0] nxt_sync2;
  logic                    tck_prev_ff;
  logic                    upd_prev_ff;
  logic                    nxt_tck_prev;
  logic                    nxt_upd_prev;

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_sync1    = {tp_bank, tp_update, tp_prog_sel, tp_tdi, tp_tck};
    nxt_sync2    = sync1_ff;
    nxt_tck_prev = sync2_ff[`UNVM_SYNC_TCK];
    nxt_upd_prev = sync2_ff[`UNVM_SYNC_UPD];
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync1_ff    <= '0;
      sync2_ff    <= '0;
      tck_prev_ff <= 1'b0;
      upd_prev_ff <= 1'b0;
    end else begin
      sync1_ff    <= nxt_sync1;
      sync2_ff    <= nxt_sync2;
      tck_prev_ff <= nxt_tck_prev;
      upd_prev_ff <= nxt_upd_prev;
    end
  end

  logic       tck_rise;
  logic       upd_rise;
  logic       sel_s;
  logic       tdi_s;
  unvm_bank_t bank_s;

  // Edges are seen on the second stage only; tck must be slow against clk_sys.
  always_comb begin
    tck_rise = sync2_ff[`UNVM_SYNC_TCK] & ~tck_prev_ff;
    upd_rise = sync2_ff[`UNVM_SYNC_UPD] & ~upd_prev_ff;
    sel_s    = sync2_ff[`UNVM_SYNC_SEL];
    tdi_s    = sync2_ff[`UNVM_SYNC_TDI];
    bank_s   = sync2_ff[`UNVM_SYNC_BANK_MSB:`UNVM_SYNC_BANK_LSB];
  end

  // --------------------------------------------------------------------------
  // Bank load shift register
  // --------------------------------------------------------------------------
  unvm_bank_bits_t shadow_ff;
  unvm_bank_bits_t nxt_shadow;
  logic [7:0]      shift_cnt_ff;
  logic [7:0]      nxt_shift_cnt;
  unvm_state_t     state_ff;
  unvm_state_t     nxt_state;

  // Bits enter at the top so the first bit shifted ends up as bit 0.
  // A load that runs past one bank saturates the count and is rejected later.
  always_comb begin
    nxt_shadow    = shadow_ff;
    nxt_shift_cnt = shift_cnt_ff;
    if (!sel_s) begin
      nxt_shift_cnt = `UNVM_CNT_ZERO;
    end else if (tck_rise && (state_ff == UNVM_ST_IDLE)) begin
      nxt_shadow = {tdi_s, shadow_ff[`UNVM_BANK_BITS-1:1]};
      if (shift_cnt_ff != `UNVM_SHIFT_SAT) begin
        nxt_shift_cnt = shift_cnt_ff + `UNVM_CNT_ONE;
      end
    end else if (upd_rise) begin
      nxt_shift_cnt = `UNVM_CNT_ZERO;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shadow_ff    <= '0;
      shift_cnt_ff <= `UNVM_CNT_ZERO;
    end else begin
      shadow_ff    <= nxt_shadow;
      shift_cnt_ff <= nxt_shift_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // Erase and program sequencer
  // --------------------------------------------------------------------------
  logic [7:0] tmr_ff;
  logic [7:0] nxt_tmr;
  unvm_bank_t tgt_bank_ff;
  unvm_bank_t nxt_tgt_bank;
  logic       done_ff;
  logic       nxt_done;
  logic       reject_ff;
  logic       nxt_reject;
  logic       erase_stb;
  logic       write_stb;
  logic       commit_ok;

  // Exactly one full bank must have been shifted in, no more and no fewer.
  always_comb begin
    commit_ok = (shift_cnt_ff == `UNVM_SHIFT_FULL);
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_tmr      = tmr_ff;
    nxt_tgt_bank = tgt_bank_ff;
    nxt_done     = 1'b0;
    nxt_reject   = reject_ff;
    erase_stb    = 1'b0;
    write_stb    = 1'b0;
    case (state_ff)
      UNVM_ST_IDLE: begin
        if (sel_s && upd_rise) begin
          if (commit_ok) begin
            nxt_state    = UNVM_ST_ERASE;
            nxt_tmr      = `UNVM_ERASE_CYCLES;
            nxt_tgt_bank = bank_s;
            nxt_reject   = 1'b0;
          end else begin
            nxt_reject = 1'b1;
          end
        end
      end
      UNVM_ST_ERASE: begin
        // The erase level is applied on the last erase cycle.
        if (tmr_ff == `UNVM_CNT_ONE) begin
          erase_stb = 1'b1;
          nxt_state = UNVM_ST_WRITE;
          nxt_tmr   = `UNVM_WRITE_CYCLES;
        end else begin
          nxt_tmr = tmr_ff - `UNVM_CNT_ONE;
        end
      end
      UNVM_ST_WRITE: begin
        if (tmr_ff == `UNVM_CNT_ONE) begin
          write_stb = 1'b1;
          nxt_state = UNVM_ST_IDLE;
          nxt_tmr   = `UNVM_CNT_ZERO;
          nxt_done  = 1'b1;
        end else begin
          nxt_tmr = tmr_ff - `UNVM_CNT_ONE;
        end
      end
      default: begin
        nxt_state = UNVM_ST_IDLE;
        nxt_tmr   = `UNVM_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff    <= UNVM_ST_IDLE;
      tmr_ff      <= `UNVM_CNT_ZERO;
      tgt_bank_ff <= '0;
      done_ff     <= 1'b0;
      reject_ff   <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      tmr_ff      <= nxt_tmr;
      tgt_bank_ff <= nxt_tgt_bank;
      done_ff     <= nxt_done;
      reject_ff   <= nxt_reject;
    end
  end

  // --------------------------------------------------------------------------
  // Fabric read port
  // --------------------------------------------------------------------------
  unvm_addr_t addr_ff;
  unvm_addr_t nxt_addr;
  logic [7:0] rd_byte;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;

  // Fabric logic is on clk_sys, so the address needs no synchroniser.
  always_comb begin
    nxt_addr = rd_addr;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_ff <= '0;
    end else begin
      addr_ff <= nxt_addr;
    end
  end

  // The fabric has no write path: the store sees only the sequencer strobes.
  unvm_bank_store unvm_bank_store_inst (
    .clk_sys   (clk_sys),
    .erase_stb (erase_stb),
    .write_stb (write_stb),
    .wr_bank   (tgt_bank_ff),
    .wr_bits   (shadow_ff),
    .rd_addr   (addr_ff),
    .rd_byte   (rd_byte)
  );

  // The selected byte is the next value of the falling-edge output flop.
  always_comb begin
    nxt_rd_data = rd_byte;
  end

  // Output flop on the falling edge gives half a cycle of array access time.
  always_ff @(negedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= `UNVM_RD_RESET;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Outputs.
  always_comb begin
    rd_data     = rd_data_ff;
    prog_busy   = (state_ff != UNVM_ST_IDLE);
    prog_done   = done_ff;
    prog_reject = reject_ff;
  end

endmodule

`default_nettype wire

// ==== verilog/unvm_params.svh ====
// Constants of the user nonvolatile byte store and its read port.
// Assumes a single 25 MHz system clock; included by its bare name.
`ifndef UNVM_PARAMS_SVH
`define UNVM_PARAMS_SVH

// --------------------------------------------------------------------------
// Geometry
// --------------------------------------------------------------------------
`define UNVM_TOTAL_BITS     1024
`define UNVM_BANKS          8
`define UNVM_BANK_BITS      128
`define UNVM_BYTES_PER_BANK 16
`define UNVM_ADDR_W         7
`define UNVM_BANK_W         3
`define UNVM_BYTE_W         4
`define UNVM_ADDR_BANK_MSB  6
`define UNVM_ADDR_BANK_LSB  4
`define UNVM_ADDR_BYTE_MSB  3
`define UNVM_ADDR_BYTE_LSB  0
`define UNVM_ERASED_BANK    128'hffffffff_ffffffff_ffffffff_ffffffff
`define UNVM_RD_RESET       8'h00

// --------------------------------------------------------------------------
// Programming sequence timing
// --------------------------------------------------------------------------
`define UNVM_CLK_PERIOD_NS  40
`define UNVM_ERASE_TIME_NS  640
`define UNVM_WRITE_TIME_NS  320
`define UNVM_ERASE_CYCLES   (8'((`UNVM_ERASE_TIME_NS + `UNVM_CLK_PERIOD_NS - 1) / `UNVM_CLK_PERIOD_NS))
`define UNVM_WRITE_CYCLES   (8'((`UNVM_WRITE_TIME_NS + `UNVM_CLK_PERIOD_NS - 1) / `UNVM_CLK_PERIOD_NS))
`define UNVM_SHIFT_FULL     8'h80
`define UNVM_SHIFT_SAT      8'h81
`define UNVM_CNT_ZERO       8'h00
`define UNVM_CNT_ONE        8'h01

// --------------------------------------------------------------------------
// Synchroniser bit positions of the test-port pins
// --------------------------------------------------------------------------
`define UNVM_SYNC_W         7
`define UNVM_SYNC_TCK       0
`define UNVM_SYNC_TDI       1
`define UNVM_SYNC_SEL       2
`define UNVM_SYNC_UPD       3
`define UNVM_SYNC_BANK_LSB  4
`define UNVM_SYNC_BANK_MSB  6

`endif

// ==== verilog/unvm_pkg.sv ====
// Types shared by the user nonvolatile store and its read port.
// Assumes unvm_params.svh is on the include path.
`default_nettype none
`include "unvm_params.svh"

package unvm_pkg;

  typedef logic [`UNVM_ADDR_W-1:0]    unvm_addr_t;
  typedef logic [`UNVM_BANK_W-1:0]    unvm_bank_t;
  typedef logic [`UNVM_BYTE_W-1:0]    unvm_byte_idx_t;
  typedef logic [`UNVM_BANK_BITS-1:0] unvm_bank_bits_t;

  typedef enum logic [1:0] {
    UNVM_ST_IDLE  = 2'b00,
    UNVM_ST_ERASE = 2'b01,
    UNVM_ST_WRITE = 2'b10
  } unvm_state_t;

endpackage

`default_nettype wire
